// ==== inc/prot_cfg.svh ====
// offsets, field positions, reset values and frame figures of the protection block
`ifndef PROT_CFG_SVH
`define PROT_CFG_SVH
`define APB_CONTROL_OFS     8'h00
`define APB_STATUS_OFS      8'h04
`define APB_FRAME_OFS       8'h08
`define CTRL_STOP_BIT       0
`define CMD_GET_PROT        32'h63657367
`define CMD_SET_PROT        32'h63657373
`define CMD_SET_BORDER      32'h73646573
`define CMD_GET_BORDER      32'h73646567
`define LEN_CODE            5'h04
`define LEN_PROT            5'h1C
`define LEN_BORDER          5'h1A
`define PROT_PAYLOAD_LAST   5'h19
`define BORDER_PAYLOAD_LAST 5'h17
`define PF_DRIVER_HOT       0
`define PF_UNDERVOLT        1
`define PF_BRIDGE           2
`define PF_SWAP_ALARM       3
`define PF_LATCHED          4
`define PF_RECONNECT        5
`define BF_FROM_POSITION    0
`define BF_STOP_LOWER       1
`define BF_STOP_UPPER       2
`define BF_SWAP_DETECT      3
`define SF_SWAP             0
`define SF_ONE_LOW          1
`define SF_TWO_LOW          2
`define RST_PROT_SETTINGS   120'h00_0000_FFFF_FFFF_FFFF_FFFF_FFFF_0000
`define RST_BORDER_SETTINGS 112'h0
`endif

// ==== inc/prot_pkg.sv ====
// types shared by the protection and travel-limit block
package prot_pkg;
    typedef struct packed {
        logic [7:0]  flags;
        logic [15:0] min_host_port_voltage;
        logic [15:0] max_host_port_voltage;
        logic [15:0] max_host_port_current;
        logic [15:0] max_temperature;
        logic [15:0] max_motor_voltage;
        logic [15:0] max_motor_current;
        logic [15:0] supply_cutoff_threshold;
    } prot_settings_type;

    typedef struct packed {
        logic [15:0] upper_limit_fraction;
        logic [31:0] upper_limit_steps;
        logic [15:0] lower_limit_fraction;
        logic [31:0] lower_limit_steps;
        logic [7:0]  limit_switch_flags;
        logic [7:0]  travel_limit_flags;
    } border_settings_type;

    typedef struct packed {
        logic [15:0] motor_current;
        logic [15:0] motor_voltage;
        logic [15:0] temperature;
        logic [15:0] host_port_current;
        logic [15:0] host_port_voltage;
    } meas_type;

    typedef enum logic {RX_CODE = 1'b0, RX_BODY = 1'b1} rx_state_type;
    typedef enum logic [1:0] {ANS_ECHO = 2'b00, ANS_PROT = 2'b01, ANS_BORDER = 2'b11} ans_kind_type;
endpackage : prot_pkg

// ==== hw/protection_and_border_config.sv ====
// protection thresholds, travel limits and their command frames behind an APB slave
//
// Notes on behaviour
// - protection read: 4-byte code request, 28-byte answer opening with the code
// - undervoltage flag set: motor off while supply below cutoff threshold
// - motor current above its maximum raises the alarm
// - motor voltage above its maximum raises the alarm
// - temperature above its maximum raises the alarm
// - host port overcurrent, overvoltage or undervoltage raises the alarm
// - driver-hot flag set: driver overheat input raises the alarm
// - bridge flag set: fault from either bridge shuts the power stage
// - swap-alarm flag set: swapped travel limits raise the alarm
// - latched flag set: alarms stay until a stop command clears them
// - reconnect flag set: connection recovery enable is driven
// - limit write: 26-byte request, answered by a 4-byte code echo
// - limit read: 4-byte request, 26-byte answer in the write layout
// - position flag picks stored positions, otherwise limit switches mark limits
// - stop flags halt the motor at the lower or upper limit
// - swap detection flag halts the motor at both limits
// - swap switch flag puts switch one on the upper side
// - low-active flags invert switch one and switch two inputs
// - limit is signed 32-bit steps plus signed 16-bit 1/256 fraction
// - limit frame: flags, switch flags, two limits, 6 reserved bytes, checksum
// - protection frame: seven thresholds, flags, 7 reserved bytes, checksum
// - protection write uses the 28-byte layout, answered by code echo
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/100ps
`include "prot_cfg.svh"
module protection_and_border_config #(
    parameter int ADDR_W = 8
) (
    input  wire logic                REF_CLK,
    input  wire logic                ARST_N,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [ADDR_W-1:0]   PADDR,
    input  wire logic [31:0]         PWDATA,
    input  wire logic [3:0]          PSTRB,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire prot_pkg::meas_type  MEASURE,
    input  wire logic                DRIVER_HOT,
    input  wire logic                BRIDGE_FAULT_A,
    input  wire logic                BRIDGE_FAULT_B,
    input  wire logic                LIMIT_INPUT_ONE,
    input  wire logic                LIMIT_INPUT_TWO,
    input  wire logic [31:0]         POSITION_STEPS,
    input  wire logic [15:0]         POSITION_FRACTION,
    output logic                     ALARM,
    output logic                     MOTOR_OFF,
    output logic                     POWER_STAGE_OFF,
    output logic                     STOP_AT_LOWER,
    output logic                     STOP_AT_UPPER,
    output logic                     RECONNECT_EN
);
    // byte sum over an inclusive window of a little-endian frame
    function automatic logic [15:0] byte_sum(input logic [223:0] v, input logic [4:0] first,
                                             input logic [4:0] last);
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < 28; i++) begin
            if (5'(i) >= first && 5'(i) <= last) begin
                s = s + {8'h00, v[8*i +: 8]};
            end
        end
        return s;
    endfunction : byte_sum

    // step count and fraction folded into one signed value in 1/256 steps
    function automatic logic signed [47:0] to_fine(input logic [31:0] st, input logic [15:0] fr);
        return $signed({{8{st[31]}}, st, 8'h00}) + $signed({{32{fr[15]}}, fr});
    endfunction : to_fine

    prot_pkg::prot_settings_type   prot_q;
    prot_pkg::border_settings_type bord_q;
    prot_pkg::rx_state_type        rx_st_q;
    prot_pkg::ans_kind_type        tx_kind_q;
    logic [223:0]                  rx_q;
    logic [4:0]                    rx_cnt_q;
    logic [4:0]                    rx_len_q;
    logic [31:0]                   tx_code_q;
    logic [4:0]                    tx_len_q;
    logic [4:0]                    tx_idx_q;
    logic [7:0]                    cause_q;
    logic [7:0]                    cause_d;
    logic [7:0]                    cond;

    // bus decode
    wire        setup      = PSEL & ~PENABLE;
    wire        done       = PSEL & PENABLE & PREADY;
    wire        hit_ctl    = PADDR == ADDR_W'(`APB_CONTROL_OFS);
    wire        hit_stat   = PADDR == ADDR_W'(`APB_STATUS_OFS);
    wire        hit_frame  = PADDR == ADDR_W'(`APB_FRAME_OFS);
    wire        unmapped   = ~(hit_ctl | hit_stat | hit_frame);
    wire        stop_cmd   = done & PWRITE & hit_ctl & PSTRB[0] & PWDATA[`CTRL_STOP_BIT];
    wire        rx_wr      = done & PWRITE & hit_frame & PSTRB[0];
    wire        tx_pending = tx_idx_q < tx_len_q;
    wire        tx_pop     = done & ~PWRITE & hit_frame & tx_pending;
    wire [7:0]  byte_in    = PWDATA[7:0];

    // request framing
    wire [31:0] code_in    = {byte_in, rx_q[23:0]};
    wire        code_done  = rx_wr && rx_st_q == prot_pkg::RX_CODE && rx_cnt_q == `LEN_CODE - 5'd1;
    wire        is_get_p   = code_in == `CMD_GET_PROT;
    wire        is_get_b   = code_in == `CMD_GET_BORDER;
    wire        is_set_p   = code_in == `CMD_SET_PROT;
    wire        is_set_b   = code_in == `CMD_SET_BORDER;
    wire        body_done  = rx_wr && rx_st_q == prot_pkg::RX_BODY && rx_cnt_q == rx_len_q - 5'd1;
    wire [15:0] rx_crc     = {byte_in, rx_q[{rx_cnt_q - 5'd1, 3'b000} +: 8]};
    wire [15:0] rx_sum     = byte_sum(rx_q, `LEN_CODE, rx_cnt_q - 5'd2);
    wire        crc_ok     = rx_crc == rx_sum;
    wire        body_p     = rx_q[31:0] == `CMD_SET_PROT;
    // checksum gate
    // drop bad frames
    wire        load_prot  = body_done & crc_ok & body_p;
    wire        load_bord  = body_done & crc_ok & ~body_p;
    wire        bad_frame  = body_done & ~crc_ok;

    // answers are built from live settings; reserved bytes are constant zero
    // reserved read as zero
    wire [223:0] p_base    = {16'h0000, 56'h0, prot_q, tx_code_q};
    wire [223:0] b_base    = {32'h0000_0000, 48'h0, bord_q, tx_code_q};
    wire [15:0]  p_crc     = byte_sum(p_base, `LEN_CODE, `PROT_PAYLOAD_LAST);
    wire [15:0]  b_crc     = byte_sum(b_base, `LEN_CODE, `BORDER_PAYLOAD_LAST);
    wire [223:0] p_frame   = {p_crc, p_base[207:0]};
    wire [223:0] b_frame   = {16'h0000, b_crc, b_base[191:0]};
    wire [223:0] tx_frame  = tx_kind_q == prot_pkg::ANS_PROT   ? p_frame :
                             tx_kind_q == prot_pkg::ANS_BORDER ? b_frame : {192'h0, tx_code_q};
    wire [7:0]   tx_byte   = tx_pending ? tx_frame[{tx_idx_q, 3'b000} +: 8] : 8'h00;
    wire [31:0]  status    = {17'h0, tx_pending, RECONNECT_EN, STOP_AT_UPPER, STOP_AT_LOWER,
                              POWER_STAGE_OFF, MOTOR_OFF, ALARM, cause_q};
    wire [31:0]  rd_mux    = hit_stat ? status : hit_frame ? {24'h0, tx_byte} : 32'h0;

    // travel limits
    // fine position
    wire signed [47:0] pos_fine   = to_fine(POSITION_STEPS, POSITION_FRACTION);
    wire signed [47:0] lower_fine = to_fine(bord_q.lower_limit_steps, bord_q.lower_limit_fraction);
    wire signed [47:0] upper_fine = to_fine(bord_q.upper_limit_steps, bord_q.upper_limit_fraction);
    wire [7:0]  bf         = bord_q.travel_limit_flags;
    wire [7:0]  sf         = bord_q.limit_switch_flags;
    wire        sw_one     = LIMIT_INPUT_ONE ^ sf[`SF_ONE_LOW];
    wire        sw_two     = LIMIT_INPUT_TWO ^ sf[`SF_TWO_LOW];
    wire        sw_upper   = sf[`SF_SWAP] ? sw_one : sw_two;
    wire        sw_lower   = sf[`SF_SWAP] ? sw_two : sw_one;
    wire        from_pos   = bf[`BF_FROM_POSITION];
    wire        at_lower   = from_pos ? pos_fine <= lower_fine : sw_lower;
    wire        at_upper   = from_pos ? pos_fine >= upper_fine : sw_upper;
    // with switches a swap shows as both switches closed at once
    wire        swapped    = from_pos ? lower_fine > upper_fine : sw_one & sw_two;
    wire        halt_lo    = at_lower & (bf[`BF_STOP_LOWER] | bf[`BF_SWAP_DETECT]);
    wire        halt_hi    = at_upper & (bf[`BF_STOP_UPPER] | bf[`BF_SWAP_DETECT]);

    // alarm conditions
    wire [7:0]  pf         = prot_q.flags;
    assign cond[0] = MEASURE.motor_current > prot_q.max_motor_current;
    assign cond[1] = MEASURE.motor_voltage > prot_q.max_motor_voltage;
    assign cond[2] = MEASURE.temperature > prot_q.max_temperature;
    assign cond[3] = MEASURE.host_port_current > prot_q.max_host_port_current;
    assign cond[4] = MEASURE.host_port_voltage > prot_q.max_host_port_voltage;
    assign cond[5] = MEASURE.host_port_voltage < prot_q.min_host_port_voltage;
    assign cond[6] = DRIVER_HOT & pf[`PF_DRIVER_HOT];
    assign cond[7] = swapped & pf[`PF_SWAP_ALARM];
    // latched alarms; a condition present during the stop survives it
    assign cause_d = pf[`PF_LATCHED] ? ((cause_q & ~{8{stop_cmd}}) | cond) : cond;
    wire        cutoff_d   = pf[`PF_UNDERVOLT] & (MEASURE.motor_voltage < prot_q.supply_cutoff_threshold);
    wire        bridge_d   = pf[`PF_BRIDGE] & (BRIDGE_FAULT_A | BRIDGE_FAULT_B);

    // zero-wait slave: the answer is registered at the setup edge, ready for the access phase
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup & unmapped;
            PRDATA  <= setup && !PWRITE ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cause_q         <= 8'h00;
            ALARM           <= 1'b0;
            MOTOR_OFF       <= 1'b0;
            POWER_STAGE_OFF <= 1'b0;
            STOP_AT_LOWER   <= 1'b0;
            STOP_AT_UPPER   <= 1'b0;
            RECONNECT_EN    <= 1'b0;
        end else begin
            cause_q         <= cause_d;
            ALARM           <= |cause_d;
            MOTOR_OFF       <= cutoff_d;
            POWER_STAGE_OFF <= bridge_d;
            STOP_AT_LOWER   <= halt_lo;
            STOP_AT_UPPER   <= halt_hi;
            RECONNECT_EN    <= pf[`PF_RECONNECT];
        end
    end

    // request assembly; an unknown code throws away the four bytes seen so far
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_st_q  <= prot_pkg::RX_CODE;
            rx_q     <= 224'h0;
            rx_cnt_q <= 5'h00;
            rx_len_q <= `LEN_CODE;
        end else if (rx_wr) begin
            rx_q[{rx_cnt_q, 3'b000} +: 8] <= byte_in;
            rx_cnt_q <= rx_cnt_q + 5'd1;
            if (code_done) begin
                rx_st_q  <= is_set_p | is_set_b ? prot_pkg::RX_BODY : prot_pkg::RX_CODE;
                rx_len_q <= is_set_p ? `LEN_PROT : `LEN_BORDER;
                rx_cnt_q <= is_set_p | is_set_b ? `LEN_CODE : 5'h00;
            end else if (body_done) begin
                rx_st_q  <= prot_pkg::RX_CODE;
                rx_cnt_q <= 5'h00;
            end
        end
    end

    // stored settings; reserved request bytes count only in the checksum
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            prot_q <= `RST_PROT_SETTINGS;
            bord_q <= `RST_BORDER_SETTINGS;
        end else begin
            if (load_prot) begin
                prot_q <= rx_q[32 +: 120];
            end
            if (load_bord) begin
                bord_q <= rx_q[32 +: 112];
            end
        end
    end

    // answer queue; a new request replaces an answer not yet read out
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tx_kind_q <= prot_pkg::ANS_ECHO;
            tx_code_q <= 32'h0000_0000;
            tx_len_q  <= 5'h00;
            tx_idx_q  <= 5'h00;
        end else if (code_done && (is_get_p || is_get_b)) begin
            tx_kind_q <= is_get_p ? prot_pkg::ANS_PROT : prot_pkg::ANS_BORDER;
            tx_code_q <= code_in;
            tx_len_q  <= is_get_p ? `LEN_PROT : `LEN_BORDER;
            tx_idx_q  <= 5'h00;
        end else if (load_prot || load_bord) begin
            tx_kind_q <= prot_pkg::ANS_ECHO;
            tx_code_q <= rx_q[31:0];
            tx_len_q  <= `LEN_CODE;
            tx_idx_q  <= 5'h00;
        end else if (tx_pop) begin
            tx_idx_q  <= tx_idx_q + 5'd1;
        end
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!ARST_N);

    property p_get_prot_answer;
        code_done && is_get_p |=> tx_len_q == `LEN_PROT && tx_idx_q == 5'h00 && tx_code_q == `CMD_GET_PROT;
    endproperty
    a_get_prot_answer: assert property (p_get_prot_answer) else $error("protection read answer not queued");

    property p_cutoff;
        pf[`PF_UNDERVOLT] && MEASURE.motor_voltage < prot_q.supply_cutoff_threshold |=> MOTOR_OFF;
    endproperty
    a_cutoff: assert property (p_cutoff) else $error("motor not switched off at low supply");

    property p_cutoff_off;
        !pf[`PF_UNDERVOLT] |=> !MOTOR_OFF;
    endproperty
    a_cutoff_off: assert property (p_cutoff_off) else $error("motor off with cutoff disabled");

    property p_over_current;
        MEASURE.motor_current > prot_q.max_motor_current |=> ALARM && cause_q[0];
    endproperty
    a_over_current: assert property (p_over_current) else $error("overcurrent alarm missing");

    property p_over_voltage;
        MEASURE.motor_voltage > prot_q.max_motor_voltage |=> ALARM && cause_q[1];
    endproperty
    a_over_voltage: assert property (p_over_voltage) else $error("overvoltage alarm missing");

    property p_over_temp;
        MEASURE.temperature > prot_q.max_temperature |=> ALARM && cause_q[2];
    endproperty
    a_over_temp: assert property (p_over_temp) else $error("temperature alarm missing");

    property p_host_port;
        MEASURE.host_port_current > prot_q.max_host_port_current
            || MEASURE.host_port_voltage > prot_q.max_host_port_voltage
            || MEASURE.host_port_voltage < prot_q.min_host_port_voltage |=> ALARM;
    endproperty
    a_host_port: assert property (p_host_port) else $error("host port alarm missing");

    property p_driver_hot;
        DRIVER_HOT && pf[`PF_DRIVER_HOT] |=> ALARM && cause_q[6];
    endproperty
    a_driver_hot: assert property (p_driver_hot) else $error("driver overheat alarm missing");

    property p_bridge;
        pf[`PF_BRIDGE] && (BRIDGE_FAULT_A || BRIDGE_FAULT_B) |=> POWER_STAGE_OFF;
    endproperty
    a_bridge: assert property (p_bridge) else $error("power stage not shut on bridge fault");

    property p_latched;
        ALARM && pf[`PF_LATCHED] && !stop_cmd |=> ALARM && (cause_q & $past(cause_q)) == $past(cause_q);
    endproperty
    a_latched: assert property (p_latched) else $error("latched alarm dropped without stop");

    property p_halt_both;
        bf[`BF_SWAP_DETECT] && at_lower && at_upper |=> STOP_AT_LOWER && STOP_AT_UPPER;
    endproperty
    a_halt_both: assert property (p_halt_both) else $error("motor not halted at both limits");

    property p_swap_alarm;
        pf[`PF_SWAP_ALARM] && swapped |=> ALARM && cause_q[7];
    endproperty
    a_swap_alarm: assert property (p_swap_alarm) else $error("swapped limits alarm missing");

    property p_reconnect;
        pf[`PF_RECONNECT] |=> RECONNECT_EN;
    endproperty
    a_reconnect: assert property (p_reconnect) else $error("reconnect enable not driven");

    property p_stop_lower;
        at_lower && bf[`BF_STOP_LOWER] |=> STOP_AT_LOWER;
    endproperty
    a_stop_lower: assert property (p_stop_lower) else $error("motor not halted at lower limit");

    property p_bad_crc;
        bad_frame |=> $stable(prot_q) && $stable(bord_q) && $stable(tx_len_q);
    endproperty
    a_bad_crc: assert property (p_bad_crc) else $error("settings changed by bad frame");

    property p_echo;
        load_prot || load_bord |=> tx_len_q == `LEN_CODE && tx_kind_q == prot_pkg::ANS_ECHO
            && (tx_code_q == `CMD_SET_PROT || tx_code_q == `CMD_SET_BORDER);
    endproperty
    a_echo: assert property (p_echo) else $error("write not answered by code echo");

    c_prot_write: cover property (load_prot ##[1:200] tx_pop);
    c_border_read: cover property (code_done && is_get_b ##[1:300] !tx_pending);
    c_latched_stop: cover property (ALARM && pf[`PF_LATCHED] ##1 stop_cmd ##1 !ALARM);
    c_bad_frame: cover property (bad_frame);
    c_swap_halt: cover property (bf[`BF_SWAP_DETECT] && swapped ##1 STOP_AT_LOWER && STOP_AT_UPPER);
endmodule : protection_and_border_config

// ==== sim/apb_host.sv ====
// behavioural host that drives the block's register bus
`timescale 1ns/100ps
module apb_host (
    input  wire logic        clk,
    output logic             psel = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite = 1'b0,
    output logic [7:0]       paddr = 8'h00,
    output logic [31:0]      pwdata = 32'h0,
    output logic [3:0]       pstrb = 4'hF,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic tmo = 1'b0;

    // request held until pready is sampled high; bounded so a dead slave cannot hang the run
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) tmo = 1'b1;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host

// ==== sim/protection_and_border_config_test.sv ====
// self-checking bench: command frames, protection alarms and travel limits
`timescale 1ns/100ps
`include "prot_cfg.svh"
module protection_and_border_config_test;
    logic               ref_clk = 1'b0;
    logic               arst_n = 1'b0;
    logic               psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic [3:0]         pstrb;
    prot_pkg::meas_type meas = '0;
    logic               hot = 1'b0, fa = 1'b0, fb = 1'b0, in1 = 1'b0, in2 = 1'b0;
    logic [31:0]        pos = 32'h0;
    logic [15:0]        posf = 16'h0;
    logic               alarm, motor_off, stage_off, stop_lo, stop_hi, reconn;
    int                 n_fail = 0;
    int                 checks = 0;
    logic [31:0]        seed = 32'h8BB5;
    logic [7:0]         pay [0:21];
    logic [7:0]         keep [0:21];
    logic [7:0]         fr [0:27];
    logic [15:0]        t [0:6];

    initial forever #5 ref_clk = ~ref_clk;

    apb_host u_host (.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    protection_and_border_config u_dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .MEASURE(meas), .DRIVER_HOT(hot), .BRIDGE_FAULT_A(fa), .BRIDGE_FAULT_B(fb),
        .LIMIT_INPUT_ONE(in1), .LIMIT_INPUT_TWO(in2), .POSITION_STEPS(pos), .POSITION_FRACTION(posf),
        .ALARM(alarm), .MOTOR_OFF(motor_off), .POWER_STAGE_OFF(stage_off), .STOP_AT_LOWER(stop_lo),
        .STOP_AT_UPPER(stop_hi), .RECONNECT_EN(reconn));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic final_report();
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(w, a, d, rd, er);
        if (u_host.tmo) begin
            n_fail++;
            final_report();
        end
    endtask : apb

    task automatic st(input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, `APB_STATUS_OFS, 32'h0);
        cmp(rd & m, e);
    endtask : st

    // code little-endian, payload, byte-sum checksum last
    task automatic mk(input logic [31:0] c, input int n);
        logic [15:0] s;
        s = 16'h0;
        for (int i = 0; i < 4; i++) fr[i] = c[8*i +: 8];
        for (int i = 4; i < n - 2; i++) begin
            fr[i] = pay[i-4];
            s += 16'(pay[i-4]);
        end
        fr[n-2] = s[7:0];
        fr[n-1] = s[15:8];
    endtask : mk

    task automatic send(input int n, input logic [7:0] bad);
        for (int i = 0; i < n; i++) apb(1'b1, `APB_FRAME_OFS, {24'h0, fr[i] ^ (i == n - 1 ? bad : 8'h00)});
    endtask : send

    task automatic recv(input int n);
        for (int i = 0; i < n; i++) begin
            apb(1'b0, `APB_FRAME_OFS, 32'h0);
            cmp(rd, {24'h0, fr[i]});
        end
    endtask : recv

    task automatic prot(input logic [7:0] fl);
        for (int i = 0; i < 7; i++) {pay[2*i+1], pay[2*i]} = t[i];
        pay[14] = fl;
        for (int i = 15; i < 22; i++) pay[i] = 8'(rnd());
        mk(`CMD_SET_PROT, 28);
        send(28, 8'h00);
        recv(4);
    endtask : prot

    task automatic border(input logic [7:0] bf, input logic [7:0] sf);
        pay[0] = bf;
        pay[1] = sf;
        {pay[5], pay[4], pay[3], pay[2]} = 32'hFFFF_FF9C;
        {pay[7], pay[6]} = {9'h0, 7'(rnd())};
        {pay[11], pay[10], pay[9], pay[8]} = 32'h0000_0064;
        {pay[13], pay[12]} = 16'hFF80;
        for (int i = 14; i < 20; i++) pay[i] = 8'(rnd());
        mk(`CMD_SET_BORDER, 26);
        send(26, 8'h00);
        recv(4);
    endtask : border

    // safe levels everywhere, then one quantity pushed just past its threshold
    task automatic ms(input int k);
        prot_pkg::meas_type m;
        m = '{16'h0, 16'h4000, 16'h0, 16'h0, 16'h4000};
        case (k)
            0: m.motor_current = t[1] + 16'h1;
            1: m.motor_voltage = t[2] + 16'h1;
            2: m.temperature = t[3] + 16'h1;
            3: m.host_port_current = t[4] + 16'h1;
            4: m.host_port_voltage = t[5] + 16'h1;
            5: m.host_port_voltage = t[6] - 16'h1;
            6: m.motor_voltage = t[0] - 16'h1;
            default: ;
        endcase
        meas <= m;
        repeat (2) @(posedge ref_clk);
    endtask : ms

    task automatic lim(input logic [7:0] bf, input logic [7:0] sf, input logic a, input logic b,
                       input logic [31:0] p, input logic [1:0] e);
        border(bf, sf);
        in1 <= a;
        in2 <= b;
        pos <= p;
        repeat (2) @(posedge ref_clk);
        cmp({30'h0, stop_hi, stop_lo}, {30'h0, e});
    endtask : lim

    initial begin
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        st(32'h0, 32'h7FFF);
        apb(1'b0, 8'h0C, 32'h0);
        cmp({31'h0, er}, 32'h1);
        t[0] = {4'h1, 12'(rnd())};
        for (int i = 1; i < 6; i++) t[i] = {2'b10, 14'(rnd())};
        t[6] = {4'h1, 12'(rnd())};
        ms(7);
        prot(8'h07);
        keep = pay;
        pay[0] ^= 8'hFF;
        mk(`CMD_SET_PROT, 28);
        send(28, 8'h01);
        st(32'h0, 32'h4000);
        pay = keep;
        for (int i = 15; i < 22; i++) pay[i] = 8'h00;
        mk(`CMD_GET_PROT, 28);
        send(4, 8'h00);
        recv(28);
        for (int k = 0; k < 6; k++) begin
            ms(k);
            cmp({31'h0, alarm}, 32'h1);
            st((32'h1 << k) | 32'h100, 32'h1FF);
        end
        ms(7);
        cmp({31'h0, alarm}, 32'h0);
        hot <= 1'b1;
        fb <= 1'b1;
        ms(6);
        cmp({29'h0, alarm, motor_off, stage_off}, 32'h7);
        st(32'h740, 32'h740);
        hot <= 1'b0;
        fb <= 1'b0;
        fa <= 1'b1;
        ms(7);
        cmp({31'h0, stage_off}, 32'h1);
        fa <= 1'b0;
        prot(8'h30);
        cmp({31'h0, reconn}, 32'h1);
        ms(0);
        ms(7);
        cmp({31'h0, alarm}, 32'h1);
        apb(1'b1, `APB_CONTROL_OFS, 32'h1);
        repeat (2) @(posedge ref_clk);
        cmp({31'h0, alarm}, 32'h0);
        lim(8'h06, 8'h02, 1'b0, 1'b0, 32'h0, 2'b01);
        for (int i = 14; i < 20; i++) pay[i] = 8'h00;
        mk(`CMD_GET_BORDER, 26);
        send(4, 8'h00);
        recv(26);
        lim(8'h06, 8'h05, 1'b1, 1'b0, 32'h0, 2'b11);
        lim(8'h02, 8'h00, 1'b0, 1'b1, 32'h0, 2'b00);
        lim(8'h03, 8'h00, 1'b1, 1'b1, 32'hFFFF_FF38, 2'b01);
        lim(8'h05, 8'h00, 1'b1, 1'b1, 32'h0000_00C8, 2'b10);
        // fraction decides: exactly on the upper limit, then one 1/256 step below it
        posf <= 16'h0080;
        lim(8'h05, 8'h00, 1'b1, 1'b1, 32'h0000_0063, 2'b10);
        posf <= 16'h007F;
        lim(8'h05, 8'h00, 1'b1, 1'b1, 32'h0000_0063, 2'b00);
        prot(8'h08);
        lim(8'h08, 8'h00, 1'b1, 1'b1, 32'h0, 2'b11);
        st(32'h180, 32'h1FF);
        final_report();
    end
endmodule : protection_and_border_config_test
